// File: hw/gcc_pkg.sv
// package of constants for the general converter control block
package gcc_pkg;
  // register offsets (byte addresses, one word each)
  localparam logic [3:0] GCC_OFF_CTRL   = 4'h0;
  localparam logic [3:0] GCC_OFF_CTRL2  = 4'h4;
  localparam logic [3:0] GCC_OFF_OFFSET = 4'h8;
  localparam logic [3:0] GCC_OFF_RESULT = 4'hC;
  // control word field positions
  localparam int GCC_B_REG_EN   = 0;
  localparam int GCC_B_CONV_EN  = 1;
  localparam int GCC_B_START    = 2;
  localparam int GCC_B_CHOP     = 3;
  localparam int GCC_B_MUTE     = 4;
  localparam int GCC_B_SIGN     = 5;
  localparam int GCC_B_SE       = 6;
  // control word two field positions
  localparam int GCC_B_CLOAD    = 0;
  localparam int GCC_B_SLOAD    = 1;
  localparam int GCC_B_ATTN3    = 2;
  // offset word field positions
  localparam int GCC_F_OFFP_LSB = 0;
  localparam int GCC_F_OFFN_LSB = 16;
  // reset values
  localparam logic [9:0] GCC_OFFSET_RST = 10'h200;
  localparam logic [9:0] GCC_RESULT_RST = 10'h000;
  // timing: conversion phase of one 16 MHz period at 200 MHz
  localparam int GCC_CLK_MHZ      = 200;
  localparam int GCC_CONV_REF_MHZ = 16;
  localparam int GCC_CONV_CYCLES  = GCC_CLK_MHZ / GCC_CONV_REF_MHZ;
  typedef enum logic [0:0] {GCC_SAMPLE, GCC_CONVERT} gcc_phase_t;
endpackage

// File: hw/gcc_ctrl.sv
// general converter conversion control with register port
`timescale 1ns/1ps
// Notes on behaviour
// - enabled converter tracks input while idle
// - writing start together with the enable bit ends sampling, begins converting
// - finished conversion clears start, resumes sampling
// - conversion phase lasts one 16 MHz period
// - constant load follows its control bit
// - sampling load only during sampling phase
// - chop bit enables two-polarity chopping
// - natural zero point is mid-scale
// - attenuate bit triples single-ended zero point
// - mute ties converter input to mid-scale
// - sign inverts converter input and output
// - offset values shift zero or full scale
// - select bit chooses single-ended or differential
module gcc_ctrl
  import gcc_pkg::*;
#(
  parameter int CONV_CYCLES = GCC_CONV_CYCLES
)
(
  input  wire logic        MCLK,
  input  wire logic        NRST,
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic             REG_ENABLE,
  output logic             TRACK,
  output logic             CONVERT,
  output logic             CONST_LOAD,
  output logic             SAMPLE_LOAD,
  output logic             CHOP,
  output logic             MUTE,
  output logic             SIGN_INV,
  output logic             SINGLE_ENDED,
  output logic             ATTEN3,
  output logic      [9:0]  OFFSET_POS,
  output logic      [9:0]  OFFSET_NEG,
  input  wire logic [9:0]  CORE_RESULT
);

  // ****************************************
  // reset release and input synchronisers
  // ****************************************
  logic       rst_s1_r;
  logic       rst_n;
  logic [9:0] res_s1_r;
  logic [9:0] res_s2_r;

  // release reset through two flops, assert asynchronously
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // analog result crosses from the core; first flop read only by the second
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      res_s1_r <= 10'h000;
      res_s2_r <= 10'h000;
    end
    else
    begin
      res_s1_r <= CORE_RESULT;
      res_s2_r <= res_s1_r;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  logic       reg_en_r;
  logic       conv_en_r;
  logic       start_r;
  logic       chop_r;
  logic       mute_r;
  logic       sign_r;
  logic       se_r;
  logic       cload_r;
  logic       sload_r;
  logic       attn3_r;
  logic [9:0] offp_r;
  logic [9:0] offn_r;
  logic [9:0] result_r;
  logic       wr_ctrl;
  logic       wr_ctrl2;
  logic       wr_off;
  logic       conv_done;

  // address decode for writes
  always_comb
  begin
    wr_ctrl  = 1'b0;
    wr_ctrl2 = 1'b0;
    wr_off   = 1'b0;
    if (WR && ADDR == GCC_OFF_CTRL)
      wr_ctrl = 1'b1;
    else if (WR && ADDR == GCC_OFF_CTRL2)
      wr_ctrl2 = 1'b1;
    else if (WR && ADDR == GCC_OFF_OFFSET)
      wr_off = 1'b1;
  end

  // mode bits of the control word; start is kept separately
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_en_r  <= 1'b0;
      conv_en_r <= 1'b0;
      chop_r    <= 1'b0;
      mute_r    <= 1'b0;
      sign_r    <= 1'b0;
      se_r      <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      reg_en_r  <= WDATA[GCC_B_REG_EN];
      conv_en_r <= WDATA[GCC_B_CONV_EN];
      chop_r    <= WDATA[GCC_B_CHOP];
      mute_r    <= WDATA[GCC_B_MUTE];
      sign_r    <= WDATA[GCC_B_SIGN];
      se_r      <= WDATA[GCC_B_SE];
    end
  end

  // load and scale bits of control word two
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cload_r <= 1'b0;
      sload_r <= 1'b0;
      attn3_r <= 1'b0;
    end
    else if (wr_ctrl2)
    begin
      cload_r <= WDATA[GCC_B_CLOAD];
      sload_r <= WDATA[GCC_B_SLOAD];
      attn3_r <= WDATA[GCC_B_ATTN3];
    end
  end

  // offset pair; mid-scale reset keeps the zero point centred
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      offp_r <= GCC_OFFSET_RST;
      offn_r <= GCC_OFFSET_RST;
    end
    else if (wr_off)
    begin
      offp_r <= WDATA[GCC_F_OFFP_LSB +: 10];
      offn_r <= WDATA[GCC_F_OFFN_LSB +: 10];
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  gcc_phase_t phase_r;
  logic [7:0] conv_cnt_r;
  logic       start_req;

  // a start written without the enable bit in the same word never takes effect
  assign start_req = wr_ctrl && WDATA[GCC_B_START] && WDATA[GCC_B_CONV_EN];
  assign conv_done = (phase_r == GCC_CONVERT) && (conv_cnt_r == 8'(CONV_CYCLES - 1));

  // sampling until start, then a fixed conversion window
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_r    <= GCC_SAMPLE;
      conv_cnt_r <= 8'h00;
    end
    else
    begin
      case (phase_r)
        GCC_SAMPLE:
        begin
          conv_cnt_r <= 8'h00;
          if (start_req)
            phase_r <= GCC_CONVERT;
        end
        GCC_CONVERT:
        begin
          if (!conv_en_r)
            phase_r <= GCC_SAMPLE;      // disabling aborts, no result
          else if (conv_done)
            phase_r <= GCC_SAMPLE;
          else
            conv_cnt_r <= conv_cnt_r + 8'h01;
        end
        default:
          phase_r <= GCC_SAMPLE;
      endcase
    end
  end

  // start bit self-clears at completion; the done clear wins the cycle
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      start_r <= 1'b0;
    else if (conv_done || (phase_r == GCC_CONVERT && !conv_en_r))
      start_r <= 1'b0;
    else if (start_req && phase_r == GCC_SAMPLE)
      start_r <= 1'b1;
  end

  // result captured together with the start clear
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      result_r <= GCC_RESULT_RST;
    else if (conv_done && conv_en_r)
      result_r <= res_s2_r;
  end

  // ****************************************
  // register read port
  // ****************************************
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      RDATA <= 32'h0000_0000;
    else if (!RD)
      RDATA <= 32'h0000_0000;
    else if (ADDR == GCC_OFF_CTRL)
      RDATA <= {25'h0, se_r, sign_r, mute_r, chop_r, start_r, conv_en_r, reg_en_r};
    else if (ADDR == GCC_OFF_CTRL2)
      RDATA <= {29'h0, attn3_r, sload_r, cload_r};
    else if (ADDR == GCC_OFF_OFFSET)
      RDATA <= {6'h0, offn_r, 6'h0, offp_r};
    else if (ADDR == GCC_OFF_RESULT)
      RDATA <= {22'h0, result_r};
    else
      RDATA <= 32'h0000_0000;           // unmapped reads zero
  end

  // ****************************************
  // analog controls
  // ****************************************
  assign REG_ENABLE   = reg_en_r;
  assign TRACK        = conv_en_r && (phase_r == GCC_SAMPLE);
  assign CONVERT      = (phase_r == GCC_CONVERT);
  assign CONST_LOAD   = cload_r;
  assign SAMPLE_LOAD  = sload_r && conv_en_r && (phase_r == GCC_SAMPLE);
  assign CHOP         = chop_r;
  assign MUTE         = mute_r;
  assign SIGN_INV     = sign_r;
  assign SINGLE_ENDED = se_r;
  assign ATTEN3       = attn3_r;
  assign OFFSET_POS   = offp_r;
  assign OFFSET_NEG   = offn_r;

  // ****************************************
  // checks
  // ****************************************
  logic [7:0] conv_len_r;

  // phase length as seen on the pin, kept apart from the sequencer count
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      conv_len_r <= 8'h00;
    else if (CONVERT)
      conv_len_r <= conv_len_r + 8'h01;
    else
      conv_len_r <= 8'h00;
  end

  // an aborted conversion is shorter on purpose, so it is left out
  property p_start_len;
    @(posedge MCLK) disable iff (!rst_n)
    $fell(CONVERT) && $past(conv_en_r) |-> conv_len_r == 8'(CONV_CYCLES);
  endproperty
  a_start_len: assert property (p_start_len) else $error("conversion length wrong");

  property p_start_go;
    @(posedge MCLK) disable iff (!rst_n)
    start_req && !CONVERT |=> CONVERT && start_r;
  endproperty
  a_start_go: assert property (p_start_go) else $error("start not taken");

  property p_done_clear;
    @(posedge MCLK) disable iff (!rst_n)
    conv_done |=> !start_r && !CONVERT;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("start not cleared");

  property p_result;
    @(posedge MCLK) disable iff (!rst_n)
    conv_done && conv_en_r |=> result_r == $past(res_s2_r);
  endproperty
  a_result: assert property (p_result) else $error("result not updated");

  property p_ignore;
    @(posedge MCLK) disable iff (!rst_n)
    wr_ctrl && WDATA[GCC_B_START] && !WDATA[GCC_B_CONV_EN] && !CONVERT |=> !start_r;
  endproperty
  a_ignore: assert property (p_ignore) else $error("start taken while disabled");

  property p_track;
    @(posedge MCLK) disable iff (!rst_n)
    conv_en_r && !CONVERT |-> TRACK;
  endproperty
  a_track: assert property (p_track) else $error("not tracking");

  property p_sload;
    @(posedge MCLK) disable iff (!rst_n)
    CONVERT |-> !SAMPLE_LOAD;
  endproperty
  a_sload: assert property (p_sload) else $error("sampling load during conversion");

  property p_cload;
    @(posedge MCLK) disable iff (!rst_n)
    wr_ctrl2 |=> CONST_LOAD == $past(WDATA[GCC_B_CLOAD]);
  endproperty
  a_cload: assert property (p_cload) else $error("constant load wrong");

endmodule

// File: testbench/gcc_core_model.sv
// analog core stand-in that answers the control block with result codes
`timescale 1ns/1ps
// ***
// core model
// ***
module gcc_core_model
(
  input  wire logic       mute,
  input  wire logic       sign_inv,
  input  wire logic [9:0] offset_pos,
  output logic      [9:0] core_result
);
  // muted input sits at mid-scale plus a +3 offset; sign gives its bitwise inverse 0x1FC
  // held steady between writes so the two sync flops see a change only after a write
  always_comb
  begin
    if (mute)
      core_result = sign_inv ? 10'h1FC : 10'h203;
    else
      core_result = offset_pos ^ 10'h0AA;
  end
endmodule

// File: testbench/gcc_ctrl_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
// ***
// bench top
// ***
module gcc_ctrl_tb
  import gcc_pkg::*;
;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        reg_en, track, convert, cload, sload, chop, mute, sinv, se, att3;
  logic [9:0]  opos, oneg, cres;
  logic [31:0] r1, r2;
  logic [9:0]  cm [3] = '{10'h300, 10'h200, 10'h100};
  int          bad_count = 0;
  int          checked = 0;

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  gcc_ctrl gcc_ctrl_inst (.MCLK(mclk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .REG_ENABLE(reg_en), .TRACK(track),
    .CONVERT(convert), .CONST_LOAD(cload), .SAMPLE_LOAD(sload), .CHOP(chop),
    .MUTE(mute), .SIGN_INV(sinv), .SINGLE_ENDED(se), .ATTEN3(att3),
    .OFFSET_POS(opos), .OFFSET_NEG(oneg), .CORE_RESULT(cres));

  gcc_core_model gcc_core_model_inst (.mute(mute), .sign_inv(sinv),
    .offset_pos(opos), .core_result(cres));

  // compare and count; four-state equality so an unknown matches only an unknown
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe; returns just after the sampling edge
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    chk(d, exp);
  endtask

  // start one conversion, time its phase, then check the result
  task automatic conv(input logic [31:0] c, input logic [9:0] exp);
    int n;
    wr_reg(GCC_OFF_CTRL, c | 32'h4);
    chk(32'(convert), 32'h1);
    chk(32'(track), 32'h0);
    chk(32'(sload), 32'h0);
    n = 0;
    while (convert === 1'b1 && n < 100)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(32'(n), 32'(GCC_CONV_CYCLES));
    chk(32'(track), 32'h1);
    rchk(GCC_OFF_CTRL, c);
    rchk(GCC_OFF_RESULT, 32'(exp));
  endtask

  task automatic final_report;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    rchk(GCC_OFF_OFFSET, 32'h02000200);
    rchk(GCC_OFF_CTRL, 32'h0);
    chk(32'(track), 32'h0);
    $display("test reset done");
    wr_reg(GCC_OFF_CTRL, 32'h1);
    chk(32'(reg_en), 32'h1);
    repeat (4000) @(posedge mclk);
    wr_reg(GCC_OFF_CTRL, 32'h5);
    chk(32'(convert), 32'h0);
    rchk(GCC_OFF_CTRL, 32'h1);
    wr_reg(GCC_OFF_CTRL, 32'h3);
    chk(32'(track), 32'h1);
    wr_reg(GCC_OFF_CTRL2, 32'h3);
    chk(32'(cload), 32'h1);
    chk(32'(sload), 32'h1);
    $display("test enable done");
    wr_reg(GCC_OFF_OFFSET, 32'h02000200);
    conv(32'h13, 10'h203);
    rd_reg(GCC_OFF_RESULT, r1);
    conv(32'h33, 10'h1FC);
    chk(32'(mute), 32'h1);
    chk(32'(sinv), 32'h1);
    rd_reg(GCC_OFF_RESULT, r2);
    chk((r1 + r2) >> 1, 32'h1FF);
    wr_reg(GCC_OFF_OFFSET, 32'h020301FD);
    chk(32'(opos), 32'h1FD);
    chk(32'(oneg), 32'h203);
    conv(32'h03, 10'h157);
    chk(32'(mute), 32'h0);
    chk(32'(sinv), 32'h0);
    // disabling mid-conversion aborts: start clears, result keeps its value
    wr_reg(GCC_OFF_CTRL, 32'h07);
    wr_reg(GCC_OFF_CTRL, 32'h01);
    rchk(GCC_OFF_CTRL, 32'h1);
    chk(32'(convert), 32'h0);
    rchk(GCC_OFF_RESULT, 32'h157);
    $display("test calibration done");
    foreach (cm[i])
    begin
      wr_reg(GCC_OFF_OFFSET, {6'h0, cm[i], 6'h0, cm[i]});
      chk(32'(opos), 32'(cm[i]));
      chk(32'(oneg), 32'(cm[i]));
    end
    wr_reg(GCC_OFF_CTRL, 32'h4B);
    chk(32'(chop), 32'h1);
    chk(32'(se), 32'h1);
    wr_reg(GCC_OFF_CTRL2, 32'h4);
    chk(32'(att3), 32'h1);
    chk(32'(cload), 32'h0);
    chk(32'(sload), 32'h0);
    rchk(GCC_OFF_CTRL2, 32'h4);
    wr_reg(GCC_OFF_CTRL, 32'h03);
    chk(32'(se), 32'h0);
    chk(32'(chop), 32'h0);
    $display("test modes done");
    final_report();
  end

  // tests need about 4100 cycles; cut a hang at nearly five times that
  initial
  begin
    #100000;
    bad_count++;
    final_report();
  end
endmodule
